// >>> core/otl_hyst.sv
`timescale 1ns/1ps
module otl_hyst
    import otl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic eval_i,
    input wire logic [10:0] temp_i,
    input wire logic [10:0] limit_i,
    output logic trip_o
);

    logic trip_q;
    logic trip_d;
    logic above;
    logic cooled;
    logic [11:0] release_lvl;

    // the warning limit may be written below the band without the override; clamp at zero
    assign release_lvl = ({1'b0, limit_i} > HYST_DEG) ?
                         ({1'b0, limit_i} - HYST_DEG) : 12'h000;
    assign above = temp_i > limit_i;
    assign cooled = {1'b0, temp_i} <= release_lvl;

    always_comb begin
        trip_d = trip_q;
        if (eval_i && above) begin
            trip_d = 1'b1;
        end else if (eval_i && cooled) begin
            trip_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trip_q <= 1'b0;
        end else begin
            trip_q <= trip_d;
        end
    end

    assign trip_o = trip_q;

endmodule : otl_hyst

// >>> core/otl_overtemp.sv
// What this block does
// - fault threshold exponent is fixed zero, one degree per step
// - fault threshold defaults to 145, writes accepted from 120 to 165
// - temperature above fault threshold sets fault bits and raises alert
// - fault flag holds until temperature falls 20 below fault threshold
// - response defaults to ignore; bandgap faults always shut down
// - bandgap faults follow programmed retry and delay, never ignore
// - action register: act bit 7, zero bit 6, retry 5:3, delay 2:0
// - act clear: keep regulating, still set status, alert unless masked
// - act set: shut output down on fault, restart per retry field
// - retry 000: stay off until faults are cleared
// - retry 111: restart endlessly until off, power loss or other fault
// - retry writes other than 000/111 rejected with comm fault and alert
// - of retry and delay, only retry bit 5 is kept in nonvolatile store
// - delay bits are read-only copies of bit 5
// - delay 111 with retry 111 waits seven rise times before restart
// - delay 000 with retry 000 means no delay, output stays off
// - temperature above warning threshold sets warning bits and alert
// - warning flag holds until temperature falls 20 below warning level
// - warning at or above fault threshold rejected with comm fault
// - vendor override bit 4 disables the threshold ordering check
// - on restore, warning = max(fault - 25, 100)
// - warning word: upper byte zero, low byte writable, default 120
`timescale 1ns/1ps
module otl_overtemp
    import otl_pkg::*;
#(
    parameter int RISE_CYCLES = RISE_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_wdata_i,
    input wire logic clear_faults_i,
    input wire logic restore_i,
    input wire logic [10:0] nv_fault_limit_i,
    input wire logic nv_act_i,
    input wire logic nv_retry_i,
    input wire logic temp_valid_i,
    input wire logic [10:0] temp_i,
    input wire logic bandgap_ot_i,
    input wire logic run_cmd_i,
    input wire logic mask_temp_i,
    input wire logic mask_comm_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic nv_retry_o,
    output logic output_enable_o,
    output logic soft_start_o,
    output otl_status_type status_o,
    output logic smbalert_o
);

    localparam logic [DELAY_CNT_W-1:0] DELAY_CYCLES =
        DELAY_CNT_W'(RETRY_RISE_TIMES * RISE_CYCLES);

    // registers
    logic [10:0] fault_limit_q;
    logic [10:0] fault_limit_d;
    logic [7:0] warn_limit_q;
    logic [7:0] warn_limit_d;
    logic act_q;
    logic act_d;
    logic retry_q;
    logic retry_d;
    logic [7:0] vendor_ovr_q;
    logic [7:0] vendor_ovr_d;
    otl_status_type status_q;
    otl_status_type status_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic rvalid_q;
    logic smbalert_q;
    logic smbalert_d;

    // bandgap detector level from the analog side
    logic bg_s1_q;
    logic bg_s2_q;
    logic bg_s3_q;
    logic bg_lvl_q;
    logic bg_lvl_d;

    // response sequencer
    otl_resp_state_type state_q;
    otl_resp_state_type state_d;
    logic [DELAY_CNT_W-1:0] delay_cnt_q;
    logic [DELAY_CNT_W-1:0] delay_cnt_d;
    logic out_en_q;
    logic out_en_d;
    logic soft_start_q;
    logic soft_start_d;
    logic fault_trip_prev_q;
    logic bg_prev_q;

    // decode
    logic wr_fault;
    logic wr_action;
    logic wr_warn;
    logic wr_vendor;
    logic override;
    logic [10:0] fault_wr_val;
    logic [7:0] warn_wr_val;
    logic [2:0] retry_wr_val;
    logic fault_range_ok;
    logic fault_order_ok;
    logic warn_order_ok;
    logic retry_ok;
    logic fault_accept;
    logic warn_accept;
    logic action_accept;
    logic reject;
    logic [10:0] restore_warn_raw;
    logic [7:0] restore_warn;
    otl_action_type action_view;

    // comparison flags
    logic fault_trip;
    logic warn_trip;
    logic fault_event;
    logic bg_event;
    logic shut_event;
    logic cool;

    function automatic logic cmd_hit(input logic [7:0] code,
                                     input logic [7:0] want);
        cmd_hit = (code == want);
    endfunction : cmd_hit

    assign wr_fault = cmd_wr_i && cmd_hit(cmd_code_i, CMD_FAULT_LIMIT);
    assign wr_action = cmd_wr_i && cmd_hit(cmd_code_i, CMD_FAULT_ACTION);
    assign wr_warn = cmd_wr_i && cmd_hit(cmd_code_i, CMD_WARN_LIMIT);
    assign wr_vendor = cmd_wr_i && cmd_hit(cmd_code_i, CMD_VENDOR_OVR);
    assign override = vendor_ovr_q[OVR_BIT];

    // exponent bits of a write are dropped, they are not writable
    assign fault_wr_val = cmd_wdata_i[MANT_W-1:0];
    // upper byte of the warning word is read-only
    assign warn_wr_val = cmd_wdata_i[WARN_W-1:0];
    assign retry_wr_val = cmd_wdata_i[RETRY_MSB_BIT:RETRY_LSB];

    assign fault_range_ok = (fault_wr_val >= FAULT_LIMIT_MIN) &&
                            (fault_wr_val <= FAULT_LIMIT_MAX);
    assign fault_order_ok = override ||
                            (fault_wr_val > {3'h0, warn_limit_q});
    assign warn_order_ok = override ||
                           ({3'h0, warn_wr_val} < fault_limit_q);
    assign retry_ok = (retry_wr_val == RETRY_NONE) ||
                      (retry_wr_val == RETRY_ENDLESS);

    assign fault_accept = wr_fault && fault_range_ok && fault_order_ok;
    assign warn_accept = wr_warn && warn_order_ok;
    assign action_accept = wr_action && retry_ok;
    assign reject = (wr_fault && !(fault_range_ok && fault_order_ok)) ||
                    (wr_warn && !warn_order_ok) ||
                    (wr_action && !retry_ok);

    // restored warning threshold tracks the stored fault threshold
    assign restore_warn_raw = (nv_fault_limit_i >= WARN_FLOOR + WARN_OFFSET)
                              ? (nv_fault_limit_i - WARN_OFFSET)
                              : WARN_FLOOR;
    assign restore_warn = restore_warn_raw[WARN_W-1:0];

    // delay field mirrors the single stored retry bit
    assign action_view = '{act: act_q, zero: 1'b0,
                           retry: {3{retry_q}},
                           delay: {3{retry_q}}};

    always_comb begin
        fault_limit_d = fault_limit_q;
        warn_limit_d = warn_limit_q;
        act_d = act_q;
        retry_d = retry_q;
        vendor_ovr_d = vendor_ovr_q;
        if (restore_i) begin
            fault_limit_d = nv_fault_limit_i;
            warn_limit_d = restore_warn;
            act_d = nv_act_i;
            retry_d = nv_retry_i;
        end else begin
            if (fault_accept) begin
                fault_limit_d = fault_wr_val;
            end
            if (warn_accept) begin
                warn_limit_d = warn_wr_val;
            end
            if (action_accept) begin
                act_d = cmd_wdata_i[ACT_BIT];
                retry_d = cmd_wdata_i[RETRY_MSB_BIT];
            end
            if (wr_vendor) begin
                vendor_ovr_d = cmd_wdata_i[7:0];
            end
        end
    end

    always_comb begin
        rdata_d = 16'h0000;
        if (cmd_hit(cmd_code_i, CMD_FAULT_LIMIT)) begin
            rdata_d = {EXP_FIXED, fault_limit_q};
        end else if (cmd_hit(cmd_code_i, CMD_FAULT_ACTION)) begin
            rdata_d = {8'h00, action_view};
        end else if (cmd_hit(cmd_code_i, CMD_WARN_LIMIT)) begin
            rdata_d = {8'h00, warn_limit_q};
        end else if (cmd_hit(cmd_code_i, CMD_VENDOR_OVR)) begin
            rdata_d = {8'h00, vendor_ovr_q};
        end
    end

    // hysteresis comparators, evaluated on each sample
    otl_hyst u_fault_hyst (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .eval_i(temp_valid_i),
        .temp_i(temp_i),
        .limit_i(fault_limit_q),
        .trip_o(fault_trip)
    );

    otl_hyst u_warn_hyst (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .eval_i(temp_valid_i),
        .temp_i(temp_i),
        .limit_i({3'h0, warn_limit_q}),
        .trip_o(warn_trip)
    );

    // a change counts once the second and third stages agree
    assign bg_lvl_d = (bg_s2_q == bg_s3_q) ? bg_s3_q : bg_lvl_q;

    assign fault_event = fault_trip && !fault_trip_prev_q;
    assign bg_event = bg_lvl_q && !bg_prev_q;
    // bandgap trips act regardless of the act bit
    assign shut_event = (fault_event && act_q) || bg_event;
    assign cool = !fault_trip && !bg_lvl_q;

    // status bits are sticky; a set in the clearing cycle wins
    always_comb begin
        status_d = status_q;
        if (clear_faults_i) begin
            status_d = '0;
        end
        if (fault_trip || bg_lvl_q) begin
            status_d.temp_fault_summary_bit = 1'b1;
            status_d.temp_fault_status_bit = 1'b1;
        end
        if (warn_trip) begin
            status_d.temp_summary_bit = 1'b1;
            status_d.temp_warn_status_bit = 1'b1;
        end
        if (reject) begin
            status_d.comm_fault_summary_bit = 1'b1;
            status_d.invalid_data_bit = 1'b1;
        end
    end

    // alert follows unmasked sticky status
    assign smbalert_d = (!mask_temp_i && (status_d.temp_fault_summary_bit ||
                                          status_d.temp_summary_bit)) ||
                        (!mask_comm_i && status_d.comm_fault_summary_bit);

    always_comb begin
        state_d = state_q;
        delay_cnt_d = delay_cnt_q;
        soft_start_d = 1'b0;
        unique case (state_q)
            RSP_RUN: begin
                // with act clear, a sensor fault leaves regulation alone
                if (shut_event) begin
                    if (retry_q) begin
                        state_d = RSP_DELAY;
                        delay_cnt_d = DELAY_CYCLES;
                    end else begin
                        state_d = RSP_LATCHED;
                    end
                end
            end
            RSP_LATCHED: begin
                // no restart delay applies; only a clear lets it run
                if (clear_faults_i) begin
                    state_d = RSP_RUN;
                end
            end
            RSP_DELAY: begin
                if (!run_cmd_i) begin
                    state_d = RSP_RUN;
                end else if (delay_cnt_q == '0) begin
                    state_d = RSP_COOL;
                end else begin
                    delay_cnt_d = delay_cnt_q - 1'b1;
                end
            end
            RSP_COOL: begin
                // a restart only once the part has cooled
                if (!run_cmd_i) begin
                    state_d = RSP_RUN;
                end else if (cool) begin
                    state_d = RSP_RUN;
                    soft_start_d = 1'b1;
                end
            end
        endcase
    end

    assign out_en_d = run_cmd_i && (state_d == RSP_RUN);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fault_limit_q <= FAULT_LIMIT_RST;
            warn_limit_q <= WARN_LIMIT_RST;
            act_q <= ACTION_RST[ACT_BIT];
            retry_q <= ACTION_RST[RETRY_MSB_BIT];
            vendor_ovr_q <= VENDOR_OVR_RST;
        end else begin
            fault_limit_q <= fault_limit_d;
            warn_limit_q <= warn_limit_d;
            act_q <= act_d;
            retry_q <= retry_d;
            vendor_ovr_q <= vendor_ovr_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_q <= '0;
            smbalert_q <= 1'b0;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            status_q <= status_d;
            smbalert_q <= smbalert_d;
            rdata_q <= cmd_rd_i ? rdata_d : rdata_q;
            rvalid_q <= cmd_rd_i;
        end
    end

    // three-stage synchroniser for the bandgap detector
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bg_s1_q <= 1'b0;
            bg_s2_q <= 1'b0;
            bg_s3_q <= 1'b0;
            bg_lvl_q <= 1'b0;
        end else begin
            bg_s1_q <= bandgap_ot_i;
            bg_s2_q <= bg_s1_q;
            bg_s3_q <= bg_s2_q;
            bg_lvl_q <= bg_lvl_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= RSP_RUN;
            delay_cnt_q <= '0;
            out_en_q <= 1'b0;
            soft_start_q <= 1'b0;
            fault_trip_prev_q <= 1'b0;
            bg_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            delay_cnt_q <= delay_cnt_d;
            out_en_q <= out_en_d;
            soft_start_q <= soft_start_d;
            fault_trip_prev_q <= fault_trip;
            bg_prev_q <= bg_lvl_q;
        end
    end

    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;
    assign nv_retry_o = retry_q;
    assign output_enable_o = out_en_q;
    assign soft_start_o = soft_start_q;
    assign status_o = status_q;
    assign smbalert_o = smbalert_q;

endmodule : otl_overtemp

// >>> core/otl_pkg.sv
package otl_pkg;

    // command codes of the management interface
    localparam logic [7:0] CMD_FAULT_LIMIT = 8'h4f;
    localparam logic [7:0] CMD_FAULT_ACTION = 8'h50;
    localparam logic [7:0] CMD_WARN_LIMIT = 8'h51;
    localparam logic [7:0] CMD_VENDOR_OVR = 8'he5;

    // linear word layout: exponent in [15:11], mantissa in [10:0]
    localparam int MANT_W = 11;
    localparam logic [4:0] EXP_FIXED = 5'h00;
    localparam int WARN_W = 8;

    // thresholds in whole degrees
    localparam logic [10:0] FAULT_LIMIT_RST = 11'h091;
    localparam logic [10:0] FAULT_LIMIT_MIN = 11'h078;
    localparam logic [10:0] FAULT_LIMIT_MAX = 11'h0a5;
    localparam logic [7:0] WARN_LIMIT_RST = 8'h78;
    localparam logic [10:0] WARN_FLOOR = 11'h064;
    localparam logic [10:0] WARN_OFFSET = 11'h019;
    localparam logic [11:0] HYST_DEG = 12'h014;

    // action register layout
    localparam int ACT_BIT = 7;
    localparam int ZERO_BIT = 6;
    localparam int RETRY_LSB = 3;
    localparam int RETRY_MSB_BIT = 5;
    localparam logic [7:0] ACTION_RST = 8'h3f;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_ENDLESS = 3'h7;

    // vendor override register
    localparam int OVR_BIT = 4;
    localparam logic [7:0] VENDOR_OVR_RST = 8'h00;

    // restart delay: seven soft-start rise times
    localparam int RETRY_RISE_TIMES = 7;
    localparam int TON_RISE_US = 3000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RISE_CYCLES_DEF = TON_RISE_US * 1000 / CLK_PERIOD_NS;
    localparam int DELAY_CNT_W = 24;

    typedef struct packed {
        logic act;
        logic zero;
        logic [2:0] retry;
        logic [2:0] delay;
    } otl_action_type;

    typedef struct packed {
        logic temp_fault_summary_bit;
        logic temp_fault_status_bit;
        logic temp_summary_bit;
        logic temp_warn_status_bit;
        logic comm_fault_summary_bit;
        logic invalid_data_bit;
    } otl_status_type;

    typedef enum logic [1:0] {
        RSP_RUN,
        RSP_LATCHED,
        RSP_DELAY,
        RSP_COOL
    } otl_resp_state_type;

endpackage : otl_pkg

// >>> verification/otl_host.sv
`timescale 1ns/1ps
module otl_host (
    input wire logic clk_i,
    input wire logic rvalid_i,
    input wire logic [15:0] rdata_i,
    output logic cmd_wr_o,
    output logic cmd_rd_o,
    output logic [7:0] cmd_code_o,
    output logic [15:0] cmd_wdata_o
);
    initial begin
        cmd_wr_o = 1'b0;
        cmd_rd_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_wdata_o = 16'h0000;
    end
    // odd retry patterns are only sent where a refusal is expected
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk_i);
        cmd_code_o = c;
        cmd_wdata_o = d;
        cmd_wr_o = 1'b1;
        @(negedge clk_i);
        cmd_wr_o = 1'b0;
        // data is not held after the strobe, so it must not be trusted
        cmd_wdata_o = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] c, output logic [15:0] q,
                      output logic v);
        @(negedge clk_i);
        cmd_code_o = c;
        cmd_rd_o = 1'b1;
        @(negedge clk_i);
        // the valid flag stands for one cycle only, take it while it stands
        v = rvalid_i;
        q = rdata_i;
        cmd_rd_o = 1'b0;
    endtask : rd
endmodule : otl_host

// >>> verification/otl_overtemp_asserts.sv
`timescale 1ns/1ps
module otl_overtemp_chk
    import otl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic clear_faults_i,
    input wire logic temp_valid_i,
    input wire logic run_cmd_i,
    input wire logic mask_temp_i,
    input wire logic mask_comm_i,
    input wire logic [15:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic nv_retry_o,
    input wire logic output_enable_o,
    input wire logic soft_start_o,
    input wire otl_status_type status_o,
    input wire logic smbalert_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_read(c);
        cmd_rd_i && cmd_code_i == c ##1 rvalid_o;
    endsequence
    a_read_answer: assert property (cmd_rd_i |=> rvalid_o)
        else $error("read not answered");
    a_action_copy: assert property (s_read(CMD_FAULT_ACTION) |->
        !rdata_o[6] && rdata_o[4:0] == {5{rdata_o[5]}})
        else $error("action read layout wrong");
    a_retry_store: assert property (s_read(CMD_FAULT_ACTION) |->
        rdata_o[5] == nv_retry_o) else $error("stored retry bit differs");
    a_fault_word: assert property (s_read(CMD_FAULT_LIMIT) |->
        rdata_o[15:11] == EXP_FIXED &&
        rdata_o[10:0] inside {[FAULT_LIMIT_MIN:FAULT_LIMIT_MAX]})
        else $error("fault word out of form");
    a_warn_word: assert property (s_read(CMD_WARN_LIMIT) |->
        rdata_o[15:8] == 8'h00) else $error("warn upper byte set");
    a_fault_alert: assert property ($rose(status_o.temp_fault_status_bit)
        && !mask_temp_i && !$past(mask_temp_i) |->
        status_o.temp_fault_summary_bit && smbalert_o)
        else $error("fault without summary or alert");
    a_warn_alert: assert property ($rose(status_o.temp_warn_status_bit)
        && !mask_temp_i && !$past(mask_temp_i) |->
        status_o.temp_summary_bit && smbalert_o)
        else $error("warning without summary or alert");
    a_reject_cause: assert property ($rose(status_o.invalid_data_bit) |->
        status_o.comm_fault_summary_bit && $past(cmd_wr_i))
        else $error("invalid data without a write");
    a_reject_alert: assert property ($rose(status_o.comm_fault_summary_bit)
        && !mask_comm_i |-> smbalert_o) else $error("comm fault silent");
    a_flag_sticky: assert property (status_o.invalid_data_bit &&
        !clear_faults_i |=> status_o.invalid_data_bit)
        else $error("invalid data dropped early");
    a_warn_sampled: assert property ($rose(status_o.temp_warn_status_bit)
        && !status_o.temp_fault_status_bit |-> $past(temp_valid_i, 2))
        else $error("warning without a sample");
    a_restart_pulse: assert property (soft_start_o |->
        output_enable_o ##1 !soft_start_o) else $error("bad restart pulse");
    a_run_off: assert property (!run_cmd_i |=> !output_enable_o)
        else $error("output on while commanded off");
endmodule : otl_overtemp_chk

bind otl_overtemp otl_overtemp_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i),
    .clear_faults_i(clear_faults_i), .temp_valid_i(temp_valid_i),
    .run_cmd_i(run_cmd_i), .mask_temp_i(mask_temp_i),
    .mask_comm_i(mask_comm_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .nv_retry_o(nv_retry_o), .output_enable_o(output_enable_o),
    .soft_start_o(soft_start_o), .status_o(status_o),
    .smbalert_o(smbalert_o));

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
    import otl_pkg::*;
    localparam int RC = 4;
    logic clk_i, rst_b_i, cmd_wr, cmd_rd, clr_f, rest, nv_act, nv_rty;
    logic tv, bg, run, mt, mc, rvalid, nv_retry, oe, ss, alert;
    logic [7:0] code;
    logic [15:0] wdata, rdata;
    logic [10:0] nv_flt, temp;
    otl_status_type st;
    int flt = 145, wrn = 120, act = 0, rty = 1, ovr = 0, ff = 0, wf = 0;
    int errors = 0, comparisons = 0, n;
    int tt[$] = '{121, 101, 100, 146, 126, 125, 100};
    logic [31:0] seed = 32'h56968350;
    otl_overtemp #(.RISE_CYCLES(RC)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_code_i(code),
        .cmd_wdata_i(wdata), .clear_faults_i(clr_f), .restore_i(rest),
        .nv_fault_limit_i(nv_flt), .nv_act_i(nv_act), .nv_retry_i(nv_rty),
        .temp_valid_i(tv), .temp_i(temp), .bandgap_ot_i(bg), .run_cmd_i(run),
        .mask_temp_i(mt), .mask_comm_i(mc), .rdata_o(rdata), .rvalid_o(rvalid),
        .nv_retry_o(nv_retry), .output_enable_o(oe), .soft_start_o(ss),
        .status_o(st), .smbalert_o(alert));
    otl_host u_host (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
        .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd), .cmd_code_o(code),
        .cmd_wdata_o(wdata));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] mexp(input logic [7:0] c);
        case (c)
            CMD_FAULT_LIMIT: return 16'(flt);
            CMD_WARN_LIMIT: return 16'(wrn);
            CMD_FAULT_ACTION: return 16'(act * 128 + rty * 63);
            CMD_VENDOR_OVR: return 16'(ovr);
            default: return 16'h0000;
        endcase
    endfunction : mexp
    task automatic chk_rd(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t read %h expected %h", $time, g, e);
        end
    endtask : chk_rd
    task automatic chk_f(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t flag %b expected %b", $time, g, e);
        end
    endtask : chk_f
    task automatic tick(input int k);
        repeat (k) @(negedge clk_i);
    endtask : tick
    task automatic clr();
        clr_f = 1'b1;
        tick(1);
        clr_f = 1'b0;
    endtask : clr
    task automatic samp(input int t);
        tv = 1'b1;
        temp = 11'(t);
        tick(1);
        tv = 1'b0;
        temp = ~temp;
        tick(1);
    endtask : samp
    task automatic rdchk(input logic [7:0] c);
        logic [15:0] q;
        logic v;
        u_host.rd(c, q, v);
        chk_f(v, 1'b1);
        chk_rd(q, mexp(c));
        @(negedge clk_i);
    endtask : rdchk
    task automatic w(input logic [7:0] c, input logic [15:0] d);
        int m;
        logic ok;
        m = (c == CMD_WARN_LIMIT) ? int'(d[7:0]) : int'(d[10:0]);
        case (c)
            CMD_FAULT_LIMIT: ok = m >= 120 && m <= 165 && (ovr[4] || m > wrn);
            CMD_WARN_LIMIT: ok = ovr[4] || m < flt;
            CMD_FAULT_ACTION: ok = d[5:3] == 3'h0 || d[5:3] == 3'h7;
            default: ok = 1'b1;
        endcase
        u_host.wr(c, d);
        chk_f(st.invalid_data_bit, !ok);
        chk_f(st.comm_fault_summary_bit, !ok);
        chk_f(alert, !ok);
        if (ok && c == CMD_FAULT_LIMIT) flt = m;
        if (ok && c == CMD_WARN_LIMIT) wrn = m;
        if (ok && c == CMD_FAULT_ACTION) begin
            act = d[7];
            rty = d[5];
        end
        if (c == CMD_VENDOR_OVR) ovr = d[7:0];
        clr();
        rdchk(c);
    endtask : w
    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial begin
        #(25 * 20000);
        errors++;
        print_verdict();
    end
    initial begin
        {rst_b_i, clr_f, rest, nv_act, nv_rty, tv, bg, mt, mc} = '0;
        nv_flt = 11'h000;
        temp = 11'h000;
        run = 1'b1;
        tick(4);
        rst_b_i = 1'b1;
        rdchk(CMD_FAULT_LIMIT);
        rdchk(CMD_FAULT_ACTION);
        rdchk(CMD_WARN_LIMIT);
        rdchk(8'h33);
        w(CMD_FAULT_LIMIT, 16'hff77);
        w(CMD_FAULT_LIMIT, 16'd166);
        w(CMD_FAULT_LIMIT, 16'd120);
        w(CMD_FAULT_LIMIT, 16'd165);
        w(CMD_WARN_LIMIT, 16'h00a5);
        w(CMD_VENDOR_OVR, 16'h0010);
        w(CMD_WARN_LIMIT, 16'hab96);
        w(CMD_FAULT_LIMIT, 16'd130);
        w(CMD_VENDOR_OVR, 16'h0000);
        for (int r = 0; r < 8; r++)
            w(CMD_FAULT_ACTION, 16'(r * 8) | 16'(rnd() & 32'hc7));
        repeat (10)
            w(rnd() % 2 ? CMD_FAULT_LIMIT : CMD_WARN_LIMIT,
              16'(110 + rnd() % 66) | 16'(rnd() & 32'hf800));
        w(CMD_VENDOR_OVR, 16'h0010);
        w(CMD_FAULT_LIMIT, 16'd145);
        w(CMD_WARN_LIMIT, 16'd120);
        w(CMD_VENDOR_OVR, 16'h0000);
        w(CMD_FAULT_ACTION, 16'h0038);
        foreach (tt[i]) begin
            mt = rnd() & 32'h1;
            samp(tt[i]);
            if (tt[i] > flt) ff = 1;
            else if (tt[i] <= flt - 20) ff = 0;
            if (tt[i] > wrn) wf = 1;
            else if (tt[i] <= wrn - 20) wf = 0;
            clr();
            tick(1);
            chk_f(st.temp_fault_status_bit, ff);
            chk_f(st.temp_fault_summary_bit, ff);
            chk_f(st.temp_warn_status_bit, wf);
            chk_f(st.temp_summary_bit, wf);
            chk_f(alert, (ff | wf) & !mt);
            chk_f(oe, 1'b1);
        end
        mt = 1'b0;
        w(CMD_FAULT_ACTION, 16'h00b8);
        samp(146);
        samp(100);
        tick(3);
        chk_f(oe, 1'b0);
        n = 6;
        while (!ss && n < 100) begin
            tick(1);
            n++;
        end
        chk_f(n >= 7 * RC && n <= 7 * RC + 6, 1'b1);
        chk_f(oe, 1'b1);
        clr();
        w(CMD_FAULT_ACTION, 16'h0080);
        samp(146);
        samp(100);
        tick(40);
        chk_f(oe, 1'b0);
        clr();
        tick(3);
        chk_f(oe, 1'b1);
        run = 1'b0;
        tick(2);
        chk_f(oe, 1'b0);
        run = 1'b1;
        w(CMD_FAULT_ACTION, 16'h0038);
        bg = 1'b1;
        tick(8);
        chk_f(oe, 1'b0);
        bg = 1'b0;
        n = 0;
        while (!ss && n < 100) begin
            tick(1);
            n++;
        end
        chk_f(oe, 1'b1);
        clr();
        for (int i = 0; i < 2; i++) begin
            nv_flt = i ? 11'd120 : 11'd130;
            nv_act = !i;
            nv_rty = i;
            rest = 1'b1;
            tick(1);
            rest = 1'b0;
            flt = nv_flt;
            wrn = (flt - 25 < 100) ? 100 : flt - 25;
            act = nv_act;
            rty = nv_rty;
            tick(1);
            chk_f(nv_retry, rty);
            rdchk(CMD_FAULT_LIMIT);
            rdchk(CMD_WARN_LIMIT);
            rdchk(CMD_FAULT_ACTION);
        end
        print_verdict();
    end
endmodule : tb
